// file: umc_params.svh
// Offsets, field positions and reset values of the USB module control block
`ifndef UMC_PARAMS_SVH
`define UMC_PARAMS_SVH

// ==========================================
// Register offsets
`define UMC_OFF_CTRL      4'h0
`define UMC_OFF_IRQ_STAT  4'h1
`define UMC_OFF_IRQ_MASK  4'h2

// ==========================================
// Control register fields
`define UMC_BIT_SUSPEND   1
`define UMC_BIT_RESUME    2
`define UMC_BIT_ATTACH    3
`define UMC_BIT_PKT_OFF   4
`define UMC_BIT_SE0       5
`define UMC_BIT_PPRST     6
`define UMC_CTRL_RESET    8'h00

// ==========================================
// Interrupt status fields
`define UMC_IRQ_SETUP     0
`define UMC_IRQ_SE0_ON    1
`define UMC_IRQ_SE0_OFF   2
`define UMC_IRQ_ATTACH_NG 3
`define UMC_IRQ_W         4

`endif

// file: umc_pkg.sv
// Types of the USB module control block
`default_nettype none
package umc_pkg;
	// Attach state, Gray coded along detached, attached, suspended
	typedef enum logic [1:0] {
		UMC_DETACHED  = 2'b00,
		UMC_ATTACHED  = 2'b01,
		UMC_SUSPENDED = 2'b11
	} umc_state_t;
endpackage
`default_nettype wire

// file: umc_sync_if.sv
// Interface carrying a raw level into the synchroniser and the settled level out
`timescale 1ns/100ps
`default_nettype none
interface umc_sync_if;
	logic raw;
	logic settled;
	modport sync (input raw, output settled);
	modport user (output raw, input settled);
endinterface
`default_nettype wire

// file: umc_sync2.sv
// Two-stage level synchroniser
`timescale 1ns/100ps
`default_nettype none
module umc_sync2 (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_ce,
	// Levels
	umc_sync_if.sync  s
);
	logic meta_r;
	logic hold_r;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			meta_r <= 1'b0;
			hold_r <= 1'b0;
		end else if (i_ce) begin
			meta_r <= s.raw;
			hold_r <= meta_r;
		end
	end

	assign s.settled = hold_r;
endmodule // umc_sync2
`default_nettype wire

// file: umc_irq.sv
// Sticky interrupt status with mask and clear-on-read
`include "umc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module umc_irq (
	// Clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_resetn,
	input  wire logic                    i_ce,
	// Events and software access
	input  wire logic [`UMC_IRQ_W-1:0]   i_event,
	input  wire logic                    i_rd_clear,
	input  wire logic                    i_mask_we,
	input  wire logic [`UMC_IRQ_W-1:0]   i_mask_wdata,
	// State
	output logic      [`UMC_IRQ_W-1:0]   o_status,
	output logic      [`UMC_IRQ_W-1:0]   o_mask,
	output logic                         o_irq
);
	logic [`UMC_IRQ_W-1:0] stat_r;
	logic [`UMC_IRQ_W-1:0] stat_nxt;
	logic [`UMC_IRQ_W-1:0] mask_r;

	// New events win over the read that clears
	assign stat_nxt = (i_rd_clear ? {`UMC_IRQ_W{1'b0}} : stat_r) | i_event;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			stat_r <= {`UMC_IRQ_W{1'b0}};
			mask_r <= {`UMC_IRQ_W{1'b0}};
		end else if (i_ce) begin
			stat_r <= stat_nxt;
			if (i_mask_we)
				mask_r <= i_mask_wdata;
		end
	end

	assign o_status = stat_r;
	assign o_mask   = mask_r;
	assign o_irq    = |(stat_r & mask_r);
endmodule // umc_irq
`default_nettype wire

// file: umc_ctrl.sv
// USB module control register, attach state and serial-engine controls
//
// Added by the designer: the placing of the registers and the strobed register port.
`include "umc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module umc_ctrl (
	// Clock, reset, enable
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_ce,
	// Register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// Serial engine side
	input  wire logic        i_clk_active,
	input  wire logic        i_pullup_enable,
	input  wire logic        i_se0_raw,
	input  wire logic        i_setup_token,
	output logic             o_module_enable,
	output logic             o_pullup_on,
	output logic             o_pingpong_buffer_indicator_clear,
	output logic             o_pingpong_pointer_reset,
	output logic             o_packet_processing_disable,
	output logic             o_resume_drive,
	output logic             o_serial_engine_clk_en,
	// Interrupt
	output logic             o_irq
);
	// ==========================================
	// Register decode
	wire hit_ctrl  = (i_addr == `UMC_OFF_CTRL);
	wire hit_stat  = (i_addr == `UMC_OFF_IRQ_STAT);
	wire hit_mask  = (i_addr == `UMC_OFF_IRQ_MASK);
	wire wr_ctrl   = i_wr & hit_ctrl;
	wire wr_mask   = i_wr & hit_mask;
	wire rd_stat   = i_rd & hit_stat;

	// ==========================================
	// Write data fields
	wire wr_att    = i_wdata[`UMC_BIT_ATTACH];
	wire wr_pprst  = i_wdata[`UMC_BIT_PPRST];
	wire wr_pkt    = i_wdata[`UMC_BIT_PKT_OFF];
	wire wr_resume = i_wdata[`UMC_BIT_RESUME];
	wire wr_susp   = i_wdata[`UMC_BIT_SUSPEND];

	// ==========================================
	// Control state
	logic                attach_r;
	logic                attach_nxt;
	logic                pprst_r;
	logic                pprst_nxt;
	logic                pkt_off_r;
	logic                pkt_off_nxt;
	logic                resume_r;
	logic                resume_nxt;
	logic                suspend_r;
	logic                suspend_nxt;
	logic                ind_clr_r;
	logic                ind_clr_nxt;
	logic                se0_prev_r;
	logic [7:0]          rdata_r;
	logic [7:0]          rdata_nxt;
	umc_pkg::umc_state_t state_r;
	umc_pkg::umc_state_t state_nxt;

	// ==========================================
	// Attach enable
	// A write of one with no clock source is refused; once set, attach
	// holds if the clock drops, so only software can detach the device
	wire clk_ok     = i_clk_active | attach_r;
	wire att_rise   = attach_nxt & ~attach_r;
	wire att_refuse = wr_ctrl & wr_att & ~attach_r & ~i_clk_active;
	assign attach_nxt = wr_ctrl ? (wr_att & clk_ok) : attach_r;

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			attach_r <= 1'b0;
		else if (i_ce)
			attach_r <= attach_nxt;
	end

	// ==========================================
	// Pingpong indicator clear
	// Registered so the descriptor table sees a clean one-cycle pulse
	assign ind_clr_nxt = att_rise;

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			ind_clr_r <= 1'b0;
		else if (i_ce)
			ind_clr_r <= ind_clr_nxt;
	end

	// ==========================================
	// Pointer reset
	// A level, held while the bit stays written to one
	assign pprst_nxt = wr_ctrl ? wr_pprst : pprst_r;

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			pprst_r <= 1'b0;
		else if (i_ce)
			pprst_r <= pprst_nxt;
	end

	// ==========================================
	// Packet processing disable
	// Setup tokens only count while attached
	wire setup_hit = attach_r & i_setup_token;
	wire pkt_clear = wr_ctrl & ~wr_pkt;
	// Hardware set beats the software clear in the same cycle
	assign pkt_off_nxt = setup_hit ? 1'b1 : (pkt_clear ? 1'b0 : pkt_off_r);

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			pkt_off_r <= 1'b0;
		else if (i_ce)
			pkt_off_r <= pkt_off_nxt;
	end

	// ==========================================
	// Resume and suspend
	assign resume_nxt  = wr_ctrl ? wr_resume : resume_r;
	assign suspend_nxt = wr_ctrl ? wr_susp : suspend_r;

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			resume_r <= 1'b0;
		else if (i_ce)
			resume_r <= resume_nxt;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			suspend_r <= 1'b0;
		else if (i_ce)
			suspend_r <= suspend_nxt;
	end

	// ==========================================
	// SE0 synchroniser
	// The bus level is not timed to this clock; two flops keep
	// metastability away from the status bit and the edge events
	umc_sync_if se0_if ();
	assign se0_if.raw = i_se0_raw;
	umc_sync2 u_se0_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_ce     (i_ce),
		.s        (se0_if.sync)
	);
	wire se0_live = se0_if.settled;

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			se0_prev_r <= 1'b0;
		else if (i_ce)
			se0_prev_r <= se0_live;
	end

	// ==========================================
	// Attach state
	always_comb begin
		case (state_r)
			umc_pkg::UMC_DETACHED:
				state_nxt = attach_r ? umc_pkg::UMC_ATTACHED : umc_pkg::UMC_DETACHED;
			umc_pkg::UMC_ATTACHED:
				state_nxt = !attach_r ? umc_pkg::UMC_DETACHED :
					suspend_r ? umc_pkg::UMC_SUSPENDED : umc_pkg::UMC_ATTACHED;
			umc_pkg::UMC_SUSPENDED:
				state_nxt = !attach_r ? umc_pkg::UMC_DETACHED :
					!suspend_r ? umc_pkg::UMC_ATTACHED : umc_pkg::UMC_SUSPENDED;
			default:
				state_nxt = umc_pkg::UMC_DETACHED;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			state_r <= umc_pkg::UMC_DETACHED;
		else if (i_ce)
			state_r <= state_nxt;
	end

	// ==========================================
	// Outputs; pull-up, pointer reset and resume are gated by attach, packet disable is forced on while detached
	wire on = attach_r;
	assign o_module_enable                   = on;
	assign o_pullup_on                       = on & i_pullup_enable;
	assign o_pingpong_buffer_indicator_clear = ind_clr_r;
	assign o_pingpong_pointer_reset          = on & pprst_r;
	assign o_packet_processing_disable       = ~on | pkt_off_r;
	assign o_resume_drive                    = on & resume_r;
	// Engine clock runs only while attached and not suspended
	assign o_serial_engine_clk_en            = (state_r == umc_pkg::UMC_ATTACHED);

	// ==========================================
	// Interrupts
	logic [`UMC_IRQ_W-1:0] irq_stat;
	logic [`UMC_IRQ_W-1:0] irq_mask;
	wire  [`UMC_IRQ_W-1:0] irq_ev;
	assign irq_ev[`UMC_IRQ_SETUP]     = setup_hit;
	assign irq_ev[`UMC_IRQ_SE0_ON]    = on & se0_live & ~se0_prev_r;
	assign irq_ev[`UMC_IRQ_SE0_OFF]   = on & ~se0_live & se0_prev_r;
	assign irq_ev[`UMC_IRQ_ATTACH_NG] = att_refuse;

	umc_irq u_irq (
		.i_clk        (i_clk),
		.i_resetn     (i_resetn),
		.i_ce         (i_ce),
		.i_event      (irq_ev),
		.i_rd_clear   (rd_stat),
		.i_mask_we    (wr_mask),
		.i_mask_wdata (i_wdata[`UMC_IRQ_W-1:0]),
		.o_status     (irq_stat),
		.o_mask       (irq_mask),
		.o_irq        (o_irq)
	);

	// ==========================================
	// Read path
	logic [7:0] ctrl_view;
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[`UMC_BIT_PPRST]   = pprst_r;
		ctrl_view[`UMC_BIT_SE0]     = se0_live;
		ctrl_view[`UMC_BIT_PKT_OFF] = pkt_off_r;
		ctrl_view[`UMC_BIT_ATTACH]  = attach_r;
		ctrl_view[`UMC_BIT_RESUME]  = resume_r;
		ctrl_view[`UMC_BIT_SUSPEND] = suspend_r;
	end

	wire [7:0] rsel =
		(i_addr == `UMC_OFF_CTRL)     ? ctrl_view :
		(i_addr == `UMC_OFF_IRQ_STAT) ? {{(8-`UMC_IRQ_W){1'b0}}, irq_stat} :
		(i_addr == `UMC_OFF_IRQ_MASK) ? {{(8-`UMC_IRQ_W){1'b0}}, irq_mask} :
		8'h00;

	// Read data stand for one cycle only and are zero otherwise
	assign rdata_nxt = i_rd ? rsel : 8'h00;

	always_ff @(posedge i_clk) begin
		if (!i_resetn)
			rdata_r <= 8'h00;
		else if (i_ce)
			rdata_r <= rdata_nxt;
	end
	assign o_rdata = rdata_r;
endmodule // umc_ctrl
`default_nettype wire

// file: umc_asserts.sv
// Concurrent checks on the USB module control ports
`timescale 1ns/100ps
`default_nettype none
module umc_asserts (
	// Clock, reset, register writes and engine side
	input wire logic	i_clk, i_resetn, i_ce, i_wr,
	input wire logic [3:0]	i_addr,
	input wire logic [7:0]	i_wdata,
	input wire logic	i_clk_active, i_pullup_enable, i_setup_token, o_module_enable,
	input wire logic	o_pullup_on, o_pingpong_buffer_indicator_clear, o_resume_drive,
	input wire logic	o_packet_processing_disable, o_serial_engine_clk_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	wire logic wr_on = i_ce && i_wr && i_addr == 4'h0 && i_wdata[3];
	sequence s_go; wr_on && !i_wdata[1] && i_clk_active; endsequence
	sequence s_run; o_module_enable ##1 o_serial_engine_clk_en; endsequence
	property p_run; s_go |=> s_run; endproperty
	a_run: assert property (p_run) else $error("engine clock idle");
	property p_sus; wr_on && i_wdata[1] && o_module_enable |-> ##2 !o_serial_engine_clk_en; endproperty
	a_sus: assert property (p_sus) else $error("engine clock runs in suspend");
	property p_pull; o_pullup_on == (o_module_enable && i_pullup_enable); endproperty
	a_pull: assert property (p_pull) else $error("pull-up wrong");
	property p_clr; $rose(o_module_enable) |-> o_pingpong_buffer_indicator_clear; endproperty
	a_clr: assert property (p_clr) else $error("no clear pulse");
	property p_att; wr_on && i_clk_active |=> o_module_enable; endproperty
	a_att: assert property (p_att) else $error("attach lost");
	property p_ref; wr_on && !i_clk_active && !o_module_enable |=> !o_module_enable; endproperty
	a_ref: assert property (p_ref) else $error("attach without clock");
	property p_det; !o_module_enable |-> o_packet_processing_disable && !o_resume_drive; endproperty
	a_det: assert property (p_det) else $error("detached but active");
	property p_stp; i_ce && o_module_enable && i_setup_token |=> o_packet_processing_disable; endproperty
	a_stp: assert property (p_stp) else $error("setup ignored");
	property p_res; o_module_enable && wr_on |=> o_resume_drive == $past(i_wdata[2]); endproperty
	a_res: assert property (p_res) else $error("resume wrong");
endmodule // umc_asserts

bind umc_ctrl umc_asserts u_asserts (
	.i_clk                             (i_clk),
	.i_resetn                          (i_resetn),
	.i_ce                              (i_ce),
	.i_wr                              (i_wr),
	.i_addr                            (i_addr),
	.i_wdata                           (i_wdata),
	.i_clk_active                      (i_clk_active),
	.i_pullup_enable                   (i_pullup_enable),
	.i_setup_token                     (i_setup_token),
	.o_module_enable                   (o_module_enable),
	.o_pullup_on                       (o_pullup_on),
	.o_pingpong_buffer_indicator_clear (o_pingpong_buffer_indicator_clear),
	.o_resume_drive                    (o_resume_drive),
	.o_packet_processing_disable       (o_packet_processing_disable),
	.o_serial_engine_clk_en            (o_serial_engine_clk_en)
);
`default_nettype wire

// file: umc_host_model.sv
// Far-end bus model: bus-reset single-ended zero and SETUP tokens on command
`timescale 1ns/100ps
`default_nettype none
module umc_host_model #(parameter int HOLD = 12) (
	// Clock, reset and commands
	input wire logic	i_clk, i_resetn, i_bus_reset, i_send_setup,
	// Bus conditions
	output var logic	o_se0_raw, o_setup_token
);
	logic [7:0] hold_r;
	always_ff @(posedge i_clk) begin
		if (!i_resetn) hold_r <= 8'h00;
		else if (i_bus_reset) hold_r <= 8'(HOLD);
		else if (hold_r != 8'h00) hold_r <= hold_r - 8'h01;
		o_setup_token <= i_send_setup;
	end
	always_comb o_se0_raw = hold_r != 8'h00;
endmodule // umc_host_model
`default_nettype wire

// file: tb.sv
// Self-checking bench of the USB module control block
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic		i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic		act = 1'b0, brst = 1'b0, snd = 1'b0, pen = 1'b1;
	logic [3:0]	i_addr = 4'h0;
	logic [7:0]	i_wdata = 8'h00;
	wire logic [7:0]	rdata, outs;
	wire logic	se0, stp, men, pull, clr, ptr, pdis, res, cken, irq;
	int		failures = 0, checks = 0;
	assign outs = {men, pull, clr, ptr, pdis, res, cken, irq};
	always #2.5 i_clk = ~i_clk;
	umc_host_model HOST (.i_clk, .i_resetn, .i_bus_reset(brst), .i_send_setup(snd),
		.o_se0_raw(se0), .o_setup_token(stp));
	umc_ctrl DUT (.i_clk, .i_resetn, .i_ce(1'b1), .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata(rdata), .i_clk_active(act), .i_pullup_enable(pen), .i_se0_raw(se0),
		.i_setup_token(stp), .o_module_enable(men), .o_pullup_on(pull),
		.o_pingpong_buffer_indicator_clear(clr), .o_pingpong_pointer_reset(ptr),
		.o_packet_processing_disable(pdis), .o_resume_drive(res),
		.o_serial_engine_clk_en(cken), .o_irq(irq));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) failures++;
		if (got !== exp) $display("mismatch %0t got %h want %h", $time, got, exp);
	endtask
	// Register access; a read compares the data of the next cycle
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= w;
		i_rd <= !w;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		#1;
		if (!w) chk(rdata, d);
	endtask
	task automatic t_detached();
		bus(1'b0, 4'h0, 8'h00);
		bus(1'b1, 4'h0, 8'h08);
		bus(1'b1, 4'h2, 8'h08);
		chk(outs, 8'h09);
		bus(1'b0, 4'h1, 8'h08);
		chk(outs, 8'h08);
	endtask
	task automatic t_attach();
		@(posedge i_clk);
		act <= 1'b1;
		// Clock source settles before attach is tried
		repeat (4) @(posedge i_clk);
		bus(1'b1, 4'h0, 8'h08);
		chk(outs, 8'hE0);
		bus(1'b1, 4'h0, 8'hCF);
		chk(outs, 8'hD6);
		@(posedge i_clk);
		#1;
		chk(outs, 8'hD4);
		bus(1'b0, 4'h0, 8'h4E);
		bus(1'b1, 4'h0, 8'h08);
	endtask
	task automatic t_host();
		@(posedge i_clk);
		snd <= 1'b1;
		@(posedge i_clk);
		snd <= 1'b0;
		#6;
		chk(outs, 8'hCA);
		bus(1'b1, 4'h0, 8'h18);
		bus(1'b0, 4'h0, 8'h18);
		bus(1'b1, 4'h0, 8'h08);
		chk(outs, 8'hC2);
		@(posedge i_clk);
		brst <= 1'b1;
		@(posedge i_clk);
		brst <= 1'b0;
		#21;
		bus(1'b0, 4'h0, 8'h28);
		#70;
		bus(1'b0, 4'h0, 8'h08);
		bus(1'b0, 4'h1, 8'h07);
		bus(1'b0, 4'hF, 8'h00);
		@(posedge i_clk);
		pen <= 1'b0;
		@(posedge i_clk);
		#1;
		chk(outs, 8'h82);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_detached();
		t_attach();
		t_host();
		test_done();
	end
	// Tests need about 64 cycles
	initial begin
		#3000;
		failures++;
		test_done();
	end
endmodule // tb
`default_nettype wire
